// [src/lcdclk_top.sv]
// lcd drive control, lcd clock divider and shared pin select registers
// Function
// RULE1 - mode 00 high sum, 01 low sum
// RULE2 - mode 10 switches low and high sums
// RULE3 - charge window 1/8 to 1/64 common period
// RULE4 - select bit picks 225K or 900K
// RULE5 - zero divisor passes oscillator clock undivided
// RULE6 - one frame every 512 lcd clocks
// RULE7 - divisor used only for options 0000,1110
// RULE8 - port0 pin2 becomes segment 19
// RULE9 - port1 pins 0-4 become segments 1-5
// RULE10 - port2 pins 0,1,5,6 become segments 9,10,14,15
// RULE11 - port3 pins become commons 1-8
// RULE12 - software writes zero to unused bits
// RULE13 - enable bit turns lcd driver on
// RULE14 - display select disables lcd or led
// RULE15 - mode 11 acts as traditional high
// RULE16 - divider pulses at divisor, reloads on write
`timescale 1ns/1ps
module lcdclk_top #(
	parameter int DIV_W = 9,
	parameter int FRAME_W = 9
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [3:0] oscillator_option,
	output logic lcd_active,
	output logic led_active,
	output logic lcd_clk_en,
	output logic frame_start,
	output logic com_start,
	output logic high_sum_900k,
	output logic low_sum_sel,
	output logic fast_window,
	output logic [18:0] seg_enable,
	output logic [7:0] com_enable
);
	import lcdclk_pkg::*;

	// all registered state of the block except the divider's
	typedef struct packed {
		logic [7:0] p0;
		logic [7:0] p1;
		logic [7:0] p2;
		logic [7:0] p3;
		logic [7:0] divh;
		logic [7:0] divl;
		logic [7:0] drv;
		logic [7:0] disp;
		logic [7:0] rdata;
		logic [FRAME_W-1:0] frame_cnt;
		logic frame_start;
		logic com_start;
		logic low_sel;
		logic fast_win;
	} lcdclk_state_t;

	lcdclk_state_t state_reg;
	lcdclk_state_t state_next;
	// decoded configuration
	lcdclk_mode_t mode;
	logic [1:0] fc_time;
	logic [DIV_W-1:0] divisor;
	logic use_div;
	logic div_reload;
	logic tick;
	logic lcd_on;
	logic [LCDCLK_COM_W-1:0] com_pos;
	logic in_window;

	// read mux; unmapped addresses read zero
	function automatic logic [7:0] read_reg(input logic [7:0] a, input lcdclk_state_t s);
		case (a)
			LCDCLK_ADDR_P0: read_reg = s.p0;
			LCDCLK_ADDR_P1: read_reg = s.p1;
			LCDCLK_ADDR_P2: read_reg = s.p2;
			LCDCLK_ADDR_P3: read_reg = s.p3;
			LCDCLK_ADDR_DIVH: read_reg = s.divh;
			LCDCLK_ADDR_DIVL: read_reg = s.divl;
			LCDCLK_ADDR_DRV: read_reg = s.drv;
			LCDCLK_ADDR_DISP: read_reg = s.disp;
			LCDCLK_ADDR_STAT: read_reg = {s.fast_win, s.low_sel, s.frame_cnt[FRAME_W-1:FRAME_W-6]};
			default: read_reg = LCDCLK_RESET_VAL;
		endcase
	endfunction : read_reg

	// write of one register, masked to its implemented bits
	function automatic logic [7:0] wr_field(input logic [7:0] old, input logic hit,
		input logic [7:0] d, input logic [7:0] m);
		wr_field = hit ? (d & m) : old;
	endfunction : wr_field

	// field decode
	// drive mode field in the low bits of the drive control register
	assign mode = lcdclk_mode_t'(state_reg.drv[LCDCLK_MODE_LSB +: 2]);
	// fast-charge time field, only meaningful in fast mode
	assign fc_time = state_reg.drv[LCDCLK_FC_LSB +: 2];
	// RULE5 nine-bit divisor
	assign divisor = {state_reg.divh[0], state_reg.divl};
	// RULE7 option gating
	assign use_div = (oscillator_option == LCDCLK_OSC_OPT_A) ||
		(oscillator_option == LCDCLK_OSC_OPT_B);
	// RULE16 reload on divisor write
	assign div_reload = reg_wr && (reg_addr == LCDCLK_ADDR_DIVH ||
		reg_addr == LCDCLK_ADDR_DIVL);
	// RULE13 enable bit, RULE14 display select
	assign lcd_on = state_reg.disp[LCDCLK_LCD_EN_BIT] && !state_reg.disp[LCDCLK_DSEL_BIT];
	// position within the current common period
	assign com_pos = state_reg.frame_cnt[LCDCLK_COM_W-1:0];

	// RULE3 window length per field value
	always_comb begin
		case (fc_time)
			// an eighth: first eight positions
			2'b00: in_window = (com_pos[5:3] == 3'h0);
			// a sixteenth: first four positions
			2'b01: in_window = (com_pos[5:2] == 4'h0);
			// a thirty-second: first two positions
			2'b10: in_window = (com_pos[5:1] == 5'h00);
			// a sixty-fourth: first position only
			2'b11: in_window = (com_pos == 6'h00);
			default: in_window = 1'b0;
		endcase
	end

	lcdclk_divider #(
		.DIV_W(DIV_W)
	) u_div (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.divisor(divisor),
		.use_divisor(use_div),
		.reload(div_reload),
		.tick(tick)
	);

	// register writes, frame counter and bias selection
	always_comb begin
		state_next = state_reg;
		// RULE12 unused bits masked off
		// port 0: only the segment 19 select
		state_next.p0 = wr_field(state_reg.p0, reg_wr && reg_addr == LCDCLK_ADDR_P0,
			reg_wdata, LCDCLK_MASK_P0);
		// port 1: segments 1-5
		state_next.p1 = wr_field(state_reg.p1, reg_wr && reg_addr == LCDCLK_ADDR_P1,
			reg_wdata, LCDCLK_MASK_P1);
		// port 2: segments 9,10 and 14,15
		state_next.p2 = wr_field(state_reg.p2, reg_wr && reg_addr == LCDCLK_ADDR_P2,
			reg_wdata, LCDCLK_MASK_P2);
		// port 3: all eight commons
		state_next.p3 = wr_field(state_reg.p3, reg_wr && reg_addr == LCDCLK_ADDR_P3,
			reg_wdata, LCDCLK_MASK_P3);
		// divisor top bit
		state_next.divh = wr_field(state_reg.divh, reg_wr && reg_addr == LCDCLK_ADDR_DIVH,
			reg_wdata, LCDCLK_MASK_DIVH);
		// divisor low byte, every bit used
		state_next.divl = wr_field(state_reg.divl, reg_wr && reg_addr == LCDCLK_ADDR_DIVL,
			reg_wdata, 8'hff);
		// drive mode, charge time and resistor select
		state_next.drv = wr_field(state_reg.drv, reg_wr && reg_addr == LCDCLK_ADDR_DRV,
			reg_wdata, LCDCLK_MASK_DRV);
		// display select and lcd enable
		state_next.disp = wr_field(state_reg.disp, reg_wr && reg_addr == LCDCLK_ADDR_DISP,
			reg_wdata, LCDCLK_MASK_DISP);
		// read data stands only in the cycle after the strobe
		state_next.rdata = reg_rd ? read_reg(reg_addr, state_reg) : LCDCLK_RESET_VAL;
		state_next.frame_start = 1'b0;
		state_next.com_start = 1'b0;
		// RULE6 frame of 512 lcd clocks
		if (!lcd_on) begin
			state_next.frame_cnt = '0;
		end else if (tick) begin
			state_next.frame_cnt = state_reg.frame_cnt + 1'b1;
			state_next.frame_start = (state_reg.frame_cnt == '1);
			// RULE15 window opens at period start
			state_next.com_start = (state_reg.frame_cnt[LCDCLK_COM_W-1:0] == '1);
		end
		// bias network selection per mode
		case (mode)
			// RULE1 traditional high sum
			LCDCLK_MODE_TRAD_HI: state_next.low_sel = 1'b0;
			// RULE1 traditional low sum
			LCDCLK_MODE_TRAD_LO: state_next.low_sel = 1'b1;
			// RULE2 fast charge switching
			LCDCLK_MODE_FAST: state_next.low_sel = lcd_on && in_window;
			// RULE15 reserved acts traditional high
			LCDCLK_MODE_RSVD: state_next.low_sel = 1'b0;
			default: state_next.low_sel = 1'b0;
		endcase
		state_next.fast_win = (mode == LCDCLK_MODE_FAST) && lcd_on && in_window;
	end

	// state register, cleared by every reset
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// outputs
	// read data from its own flop, zero when no read was made
	assign reg_rdata = state_reg.rdata;
	// RULE13 lcd driver on
	assign lcd_active = lcd_on;
	// RULE14 led side when selected
	assign led_active = state_reg.disp[LCDCLK_DSEL_BIT];
	// lcd clock enable comes straight from the divider flop
	assign lcd_clk_en = tick;
	assign frame_start = state_reg.frame_start;
	assign com_start = state_reg.com_start;
	// RULE4 high sum selection
	assign high_sum_900k = state_reg.drv[LCDCLK_RSEL_BIT];
	assign low_sum_sel = state_reg.low_sel;
	assign fast_window = state_reg.fast_win;

	// pin function selects; segment index n maps to bit n-1
	always_comb begin
		seg_enable = '0;
		// RULE9 port1 segments 1-5
		seg_enable[4:0] = state_reg.p1[4:0];
		// RULE10 port2 segments 9,10
		seg_enable[9:8] = state_reg.p2[1:0];
		// RULE10 port2 segments 14,15
		seg_enable[14:13] = state_reg.p2[6:5];
		// RULE8 port0 segment 19
		seg_enable[18] = state_reg.p0[LCDCLK_P0_BIT];
	end
	// RULE11 port3 commons
	assign com_enable = state_reg.p3;

	// RULE6 frame pulse only right after the wrap
	chk_frame_len: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE6
		frame_start |-> state_reg.frame_cnt == '0 &&
		$past(state_reg.frame_cnt) == '1 && $past(lcd_on))
		else $error("frame pulse misplaced");

	// RULE6 last lcd clock of a frame
	sequence s_frame_wrap;
		tick && lcd_on && state_reg.frame_cnt == '1;
	endsequence
	// RULE6 every wrap raises the frame mark
	chk_frame_mark: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE6
		s_frame_wrap |=> frame_start)
		else $error("frame mark missing");

	// RULE15 common period starts at position zero
	chk_com_period: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE15
		com_start |-> com_pos == '0 && $past(com_pos) == '1)
		else $error("common period mark misplaced");

	// RULE1 low sum for mode 01
	chk_mode_low: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE1
		(mode == LCDCLK_MODE_TRAD_LO && !div_reload) |=> low_sum_sel || $changed(state_reg.drv))
		else $error("mode 01 not low sum");

	// RULE15 reserved mode high sum
	chk_mode_rsvd: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE15
		(mode == LCDCLK_MODE_RSVD) |=> !low_sum_sel || $changed(state_reg.drv))
		else $error("reserved mode not high sum");

	// RULE2 window only in fast mode
	chk_fast_only: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE2
		fast_window |-> $past(mode) == LCDCLK_MODE_FAST && low_sum_sel)
		else $error("fast window outside fast mode");

	// RULE2 fast mode switches to the low sum exactly in the window
	chk_fast_switch: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE2
		(mode == LCDCLK_MODE_FAST) |=> low_sum_sel == fast_window)
		else $error("fast mode sum switching wrong");

	// RULE3 window length per field, one cycle behind the position
	chk_win_len: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE3
		(mode == LCDCLK_MODE_FAST && lcd_on) |=>
		fast_window == ($past(com_pos) < (6'h08 >> $past(fc_time))))
		else $error("fast window length wrong");

	// RULE3 window length for 1/64
	chk_win_64: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE3
		(fc_time == 2'b11 && in_window && mode == LCDCLK_MODE_FAST) |-> com_pos == 6'h00)
		else $error("1/64 window too long");

	// RULE4 resistor select follows a write
	chk_rsel_out: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE4
		(reg_wr && reg_addr == LCDCLK_ADDR_DRV) |=>
		high_sum_900k == $past(reg_wdata[LCDCLK_RSEL_BIT]))
		else $error("resistor select not applied");

	// RULE12 unused port 2 bits read zero
	chk_unused_zero: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE12
		(reg_wr && reg_addr == LCDCLK_ADDR_P2) |=> (state_reg.p2 & ~LCDCLK_MASK_P2) == 8'h00)
		else $error("unused bit stored");

	// RULE14 lcd off when led chosen
	chk_excl: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE14
		led_active |-> !lcd_active)
		else $error("lcd and led both active");

	// RULE13 no frame activity while the lcd is off
	chk_lcd_off: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE13
		!lcd_active |=> !frame_start && !com_start && !fast_window)
		else $error("lcd activity while off");

	// RULE8 pin select follows write
	sequence s_p0_write;
		reg_wr && reg_addr == LCDCLK_ADDR_P0;
	endsequence
	chk_p0_seg: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE8
		s_p0_write |=> seg_enable[18] == $past(reg_wdata[LCDCLK_P0_BIT]))
		else $error("segment 19 select wrong");

	// RULE9 port1 selects follow a write
	chk_p1_seg: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE9
		(reg_wr && reg_addr == LCDCLK_ADDR_P1) |=> seg_enable[4:0] == $past(reg_wdata[4:0]))
		else $error("segments 1-5 select wrong");

	// RULE10 port2 selects follow a write
	chk_p2_seg: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE10
		(reg_wr && reg_addr == LCDCLK_ADDR_P2) |=>
		seg_enable[9:8] == $past(reg_wdata[1:0]) && seg_enable[14:13] == $past(reg_wdata[6:5]))
		else $error("segments 9,10,14,15 select wrong");

	// RULE10 segments without a shared pin stay off
	chk_seg_gaps: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE10
		seg_enable[7:5] == 3'h0 && seg_enable[12:10] == 3'h0 && seg_enable[17:15] == 3'h0)
		else $error("unmapped segment enabled");

	// RULE11 port3 selects follow a write
	chk_p3_com: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE11
		(reg_wr && reg_addr == LCDCLK_ADDR_P3) |=> com_enable == $past(reg_wdata))
		else $error("common select wrong");

	// RULE7 other oscillator options leave the clock undivided
	chk_opt_bypass: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE7
		(!use_div && !div_reload) |=> lcd_clk_en)
		else $error("undivided clock missing");

	// RULE5 zero divisor gives an lcd clock every cycle
	chk_zero_div: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE5
		(divisor == '0 && !div_reload) |=> lcd_clk_en)
		else $error("zero divisor clock missing");
endmodule : lcdclk_top

// [src/lcdclk_pkg.sv]
// package of constants for the lcd drive clock and pin select block
package lcdclk_pkg;
	// register byte addresses on the special-function bus
	localparam logic [7:0] LCDCLK_ADDR_P1 = 8'h9c;
	localparam logic [7:0] LCDCLK_ADDR_P2 = 8'h9d;
	localparam logic [7:0] LCDCLK_ADDR_P3 = 8'h9e;
	localparam logic [7:0] LCDCLK_ADDR_DIVH = 8'haa;
	localparam logic [7:0] LCDCLK_ADDR_DRV = 8'had;
	localparam logic [7:0] LCDCLK_ADDR_DIVL = 8'hac;
	localparam logic [7:0] LCDCLK_ADDR_P0 = 8'hb6;
	localparam logic [7:0] LCDCLK_ADDR_DISP = 8'hab;
	localparam logic [7:0] LCDCLK_ADDR_STAT = 8'hae;
	// implemented-bit masks; unimplemented bits read zero
	localparam logic [7:0] LCDCLK_MASK_P0 = 8'h04;
	localparam logic [7:0] LCDCLK_MASK_P1 = 8'h1f;
	localparam logic [7:0] LCDCLK_MASK_P2 = 8'h63;
	localparam logic [7:0] LCDCLK_MASK_P3 = 8'hff;
	localparam logic [7:0] LCDCLK_MASK_DIVH = 8'h01;
	localparam logic [7:0] LCDCLK_MASK_DRV = 8'h1f;
	localparam logic [7:0] LCDCLK_MASK_DISP = 8'hc0;
	localparam logic [7:0] LCDCLK_RESET_VAL = 8'h00;
	// drive control field positions
	localparam int LCDCLK_MODE_LSB = 0;
	localparam int LCDCLK_FC_LSB = 2;
	localparam int LCDCLK_RSEL_BIT = 4;
	// display control bits
	localparam int LCDCLK_LCD_EN_BIT = 6;
	localparam int LCDCLK_DSEL_BIT = 7;
	// port 0 segment bit
	localparam int LCDCLK_P0_BIT = 2;
	// oscillator options for which the divisor applies
	localparam logic [3:0] LCDCLK_OSC_OPT_A = 4'h0;
	localparam logic [3:0] LCDCLK_OSC_OPT_B = 4'he;
	// lcd clocks per frame
	localparam int LCDCLK_FRAME_CLKS = 512;
	localparam int LCDCLK_FRAME_W = 9;
	// one common period is an eighth of a frame at the widest duty
	localparam int LCDCLK_COM_W = 6;
	// drive mode encodings
	typedef enum logic [1:0] {
		LCDCLK_MODE_TRAD_HI = 2'b00,
		LCDCLK_MODE_TRAD_LO = 2'b01,
		LCDCLK_MODE_FAST = 2'b10,
		LCDCLK_MODE_RSVD = 2'b11
	} lcdclk_mode_t;
endpackage : lcdclk_pkg

// [src/lcdclk_divider.sv]
// lcd clock divider producing one-cycle lcd clock enable pulses
`timescale 1ns/1ps
module lcdclk_divider #(
	parameter int DIV_W = 9
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [DIV_W-1:0] divisor,
	input wire logic use_divisor,
	input wire logic reload,
	output logic tick
);
	import lcdclk_pkg::*;

	// all state in one struct
	typedef struct packed {
		logic [DIV_W-1:0] cnt;
		logic tick;
	} lcdclk_div_state_t;

	lcdclk_div_state_t state_reg;
	lcdclk_div_state_t state_next;
	logic bypass;

	// zero divisor or unsupported oscillator option passes the clock through
	assign bypass = (divisor == '0) || !use_divisor;

	// next-state logic of the counter
	always_comb begin
		state_next = state_reg;
		// RULE16 reload on write
		if (reload) begin
			state_next.cnt = '0;
			state_next.tick = 1'b0;
		// RULE5 undivided when zero
		end else if (bypass) begin
			state_next.cnt = '0;
			state_next.tick = 1'b1;
		// RULE16 pulse at divisor
		end else if (state_reg.cnt + 1'b1 >= divisor) begin
			state_next.cnt = '0;
			state_next.tick = 1'b1;
		end else begin
			state_next.cnt = state_reg.cnt + 1'b1;
			state_next.tick = 1'b0;
		end
	end

	// state register
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign tick = state_reg.tick;

	// RULE5 spacing equals divisor
	// a divisor write inside the span restarts the count, so it excuses the last step
	chk_tick_spacing: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE5
		(tick && !reload && !bypass && divisor == 9'h003 && $stable(divisor))
		|=> !tick ##1 !tick ##1 (tick || $past(reload) || $past(reload, 2)))
		else $error("divided tick spacing wrong");

	// RULE7 bypass ticks every cycle
	chk_bypass_tick: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE7
		(!use_divisor && !reload) |=> tick)
		else $error("bypass tick missing");

	// RULE16 reload clears tick
	chk_reload_idle: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE16
		reload |=> !tick)
		else $error("tick after reload");
endmodule : lcdclk_divider

// [verif/lcdclk_glass_model.sv]
// segment glass model that measures lcd clocks between frame marks
`timescale 1ns/1ps
module lcdclk_glass_model (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic lcd_clk_en,
	input wire logic frame_start,
	output logic [31:0] frame_len
);
	// ticks seen since the last frame mark
	logic [31:0] tick_cnt;
	// ticks per frame
	// the tick in the frame mark cycle already belongs to the new frame
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt <= 32'h0;
			frame_len <= 32'h0;
		end else if (frame_start) begin
			frame_len <= tick_cnt;
			tick_cnt <= {31'h0, lcd_clk_en};
		end else begin
			tick_cnt <= tick_cnt + {31'h0, lcd_clk_en};
		end
	end
endmodule : lcdclk_glass_model

// [verif/lcdclk_top_tb.sv]
// self-checking bench for the lcd clock and pin select block
`timescale 1ns/1ps
module lcdclk_top_tb;
	import lcdclk_pkg::*;
	logic clk_sys;
	logic rst_n;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic [3:0] oscillator_option;
	logic lcd_active, led_active, lcd_clk_en, frame_start, com_start;
	logic high_sum_900k, low_sum_sel, fast_window;
	logic [18:0] seg_enable;
	logic [7:0] com_enable;
	logic [31:0] frame_len;
	logic [31:0] cnt;
	int num_errors;
	int checks_done;
	// mapped registers and their implemented bits, written only with legal ones
	logic [7:0] addrs [7] = '{LCDCLK_ADDR_P1, LCDCLK_ADDR_P2, LCDCLK_ADDR_P3,
		LCDCLK_ADDR_DIVH, LCDCLK_ADDR_DIVL, LCDCLK_ADDR_DRV, LCDCLK_ADDR_P0};
	logic [7:0] masks [7] = '{LCDCLK_MASK_P1, LCDCLK_MASK_P2, LCDCLK_MASK_P3,
		LCDCLK_MASK_DIVH, 8'hff, LCDCLK_MASK_DRV, LCDCLK_MASK_P0};
	lcdclk_top #(.DIV_W(9), .FRAME_W(9)) lcdclk_top_inst (.clk_sys(clk_sys), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .oscillator_option(oscillator_option),
		.lcd_active(lcd_active), .led_active(led_active), .lcd_clk_en(lcd_clk_en),
		.frame_start(frame_start), .com_start(com_start), .high_sum_900k(high_sum_900k),
		.low_sum_sel(low_sum_sel), .fast_window(fast_window), .seg_enable(seg_enable),
		.com_enable(com_enable));
	lcdclk_glass_model lcdclk_glass_model_inst (.clk_sys(clk_sys), .rst_n(rst_n),
		.lcd_clk_en(lcd_clk_en), .frame_start(frame_start), .frame_len(frame_len));
	// 40 mhz system clock
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// one-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	// one-cycle read strobe; data stand only in the following cycle
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string name);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk(name, {24'h0, reg_rdata}, {24'h0, exp});
	endtask : rdchk
	task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask : chk
	// registered outputs lag the register by a cycle, so let a few pass
	task automatic settle();
		repeat (3) @(posedge clk_sys);
		#1;
	endtask : settle
	// pulses or high cycles of one output over n cycles
	task automatic count(input int sel, input int n, output logic [31:0] c);
		c = 32'h0;
		repeat (n) begin
			@(posedge clk_sys);
			#1;
			case (sel)
				0: c += {31'h0, lcd_clk_en};
				1: c += {31'h0, frame_start};
				2: c += {31'h0, com_start};
				default: c += {31'h0, fast_window};
			endcase
		end
	endtask : count
	task automatic report_and_stop();
		$display("mismatches %0d, comparisons %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop
	// watchdog well beyond the few thousand cycles the tests need
	initial begin
		#1000000;
		num_errors++;
		report_and_stop();
	end
	// main sequence
	initial begin
		rst_n = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		oscillator_option = LCDCLK_OSC_OPT_A;
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			rdchk(addrs[i], 8'h00, "reset value");
		end
		rdchk(LCDCLK_ADDR_DISP, 8'h00, "display reset");
		rdchk(LCDCLK_ADDR_STAT, 8'h00, "status reset");
		rdchk(8'h00, 8'h00, "unmapped read");
		// fill every implemented bit outside the display register, then clear the divisor again
		for (int i = 0; i < 7; i++) begin
			wr(addrs[i], masks[i]);
			rdchk(addrs[i], masks[i], "readback");
		end
		settle();
		chk("segments", {13'h0, seg_enable}, 32'h4631f);
		chk("commons", {24'h0, com_enable}, 32'hff);
		wr(LCDCLK_ADDR_P0, 8'h00);
		settle();
		chk("segment 19 off", {13'h0, seg_enable}, 32'h0631f);
		wr(LCDCLK_ADDR_DIVH, 8'h00);
		wr(LCDCLK_ADDR_DIVL, 8'h00);
		wr(LCDCLK_ADDR_DISP, 8'h40);
		settle();
		chk("lcd on", {30'h0, lcd_active, led_active}, 32'h2);
		// traditional and reserved modes and resistor select
		for (int v = 0; v < 8; v++) begin
			if (v[1:0] != 2'b10) begin
				wr(LCDCLK_ADDR_DRV, {3'h0, v[2], 2'b00, v[1:0]});
				settle();
				chk("low sum", {31'h0, low_sum_sel}, {31'h0, v[1:0] == 2'b01});
				chk("high sum", {31'h0, high_sum_900k}, {31'h0, v[2]});
				count(3, 64, cnt);
				chk("no fast window", cnt, 32'h0);
			end
		end
		// fast charge window per common period, tick every cycle
		for (int f = 0; f < 4; f++) begin
			wr(LCDCLK_ADDR_DRV, {4'h0, f[1:0], 2'b10});
			settle();
			count(3, 64, cnt);
			chk("fast window", cnt, 32'h8 >> f);
		end
		count(1, 1024, cnt);
		chk("frames", cnt, 32'h2);
		count(2, 128, cnt);
		chk("common periods", cnt, 32'h2);
		chk("glass frame length", frame_len, 32'd512);
		// divider with both valid oscillator options and one bypassing option between them
		wr(LCDCLK_ADDR_DIVL, 8'h05);
		count(0, 3, cnt);
		chk("reload gap", cnt, 32'h0);
		settle();
		count(0, 100, cnt);
		chk("divide by 5", cnt, 32'd20);
		@(posedge clk_sys);
		oscillator_option <= 4'h3;
		settle();
		count(0, 50, cnt);
		chk("bypass option", cnt, 32'd50);
		@(posedge clk_sys);
		oscillator_option <= LCDCLK_OSC_OPT_B;
		settle();
		count(0, 100, cnt);
		chk("second option", cnt, 32'd20);
		// divide by three, the spacing the divider checker watches
		wr(LCDCLK_ADDR_DIVL, 8'h03);
		settle();
		count(0, 30, cnt);
		chk("divide by 3", cnt, 32'h0a);
		wr(LCDCLK_ADDR_DIVH, 8'h01);
		wr(LCDCLK_ADDR_DIVL, 8'h00);
		settle();
		count(0, 512, cnt);
		chk("divide by 256", cnt, 32'h2);
		wr(LCDCLK_ADDR_DIVH, 8'h00);
		settle();
		count(0, 20, cnt);
		chk("zero divisor", cnt, 32'd20);
		// led selected: lcd driver off, no frames
		wr(LCDCLK_ADDR_DISP, 8'hc0);
		settle();
		chk("led select", {30'h0, lcd_active, led_active}, 32'h1);
		count(1, 1024, cnt);
		chk("frames stopped", cnt, 32'h0);
		// mid-run reset clears every register again
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		rdchk(LCDCLK_ADDR_DISP, 8'h00, "display after reset");
		rdchk(LCDCLK_ADDR_P3, 8'h00, "commons after reset");
		report_and_stop();
	end
endmodule : lcdclk_top_tb
